// ---- far_side_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  // Clock
  input wire logic aclk,
  // CPU and pins
  output logic sleep_exec,
  output logic nmi_pin,
  output logic reset_pin_n
);
  initial begin
    sleep_exec = 1'b0;
    nmi_pin = 1'b1;
    reset_pin_n = 1'b1;
  end

  // ****************************************
  // Pin and instruction drivers
  // ****************************************
  // Idle level opposite to the wake edge before entry
  task automatic arm(input logic edge_sel);
    @(posedge aclk);
    nmi_pin <= ~edge_sel;
  endtask : arm

  task automatic sleep_now();
    @(posedge aclk);
    sleep_exec <= 1'b1;
    @(posedge aclk);
    sleep_exec <= 1'b0;
  endtask : sleep_now

  // Wake level held until the exception begins
  task automatic wake(input logic edge_sel);
    @(posedge aclk);
    nmi_pin <= edge_sel;
  endtask : wake

  task automatic pin_reset(input int len);
    @(posedge aclk);
    reset_pin_n <= 1'b0;
    repeat (len) @(posedge aclk);
    reset_pin_n <= 1'b1;
  endtask : pin_reset
endmodule : far_side_model
`default_nettype wire

// ---- standby_mode_controller.sv ----
// Summary of operation
// - Sleep with standby bit set enters standby
// - Standby stops clock, CPU and peripherals
// - CPU registers and RAM are held
// - Ports held or floated per select bit
// - Entry leaves retained controllers' registers untouched
// - Entry reinitialises DMA channel and operation control
// - DMA address and count become undefined
// - Entry reinitialises timers, serial unit, converter
// - Entry clears watchdog flags, keeps select, count
// - Only NMI or power-on reset end standby
// - NMI edge restarts oscillator, clocks watchdog only
// - Watchdog overflow resumes chip, starts NMI exception
// - Reset pin low ends standby by reset
// - Float select 0 holds, 1 floats pins
// - Standby bit refused while watchdog runs
// - Edge select 0 falling, 1 rising
`timescale 1ns/1ps
`default_nettype none
module standby_mode_controller #(
  parameter int ADDR_WIDTH = 8
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_WIDTH-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // CPU side
  input wire logic sleep_exec,
  output logic cpu_halt,
  output logic reg_retain,
  output logic nmi_exception,
  // Pins
  input wire logic nmi_pin,
  input wire logic reset_pin_n,
  // Clock gating
  output logic osc_enable,
  output logic sys_clock_enable,
  output logic wdt_clock_enable,
  // Port state
  output logic port_hold,
  output logic port_float,
  // Peripheral effects
  output logic dma_ctrl_reinit,
  output logic dma_addr_undefined,
  output logic periph_reinit,
  output logic power_on_reset
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    standby_pkg::standby_phase_type phase;
    logic standby_select_bit;
    logic port_float_select;
    logic wake_edge_select;
    logic watchdog_overflow_flag;
    logic watchdog_timer_mode_select;
    logic watchdog_run_enable;
    logic [2:0] watchdog_clock_select;
    logic [7:0] watchdog_reset_control;
    logic res_meta;
    logic res_sync;
    logic nmi_meta;
    logic nmi_sync;
    logic nmi_prev;
    logic aw_got;
    logic w_got;
    logic [ADDR_WIDTH-1:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic cpu_halt;
    logic reg_retain;
    logic nmi_exception;
    logic osc_enable;
    logic sys_clock_enable;
    logic wdt_clock_enable;
    logic port_hold;
    logic port_float;
    logic dma_ctrl_reinit;
    logic dma_addr_undefined;
    logic periph_reinit;
    logic power_on_reset;
  } ctrl_state_type;

  ctrl_state_type st;
  ctrl_state_type n;

  logic [7:0] wdt_count;
  logic wdt_overflow;
  logic wdt_count_enable;
  logic wdt_clear;
  logic wdt_load;
  logic reg_write;
  logic nmi_edge;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic hits(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] off);
    return a[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(ADDR_WIDTH'(off) >> 2);
  endfunction : hits

  function automatic logic [32:0] read_word(input logic [ADDR_WIDTH-1:0] a,
                                            input ctrl_state_type s,
                                            input logic [7:0] count);
    logic [32:0] r;
    r = '0;
    if (hits(a, standby_pkg::OFF_STANDBY_CONTROL)) begin
      r[7:0] = {s.standby_select_bit, s.port_float_select, 1'b0,
                standby_pkg::STANDBY_CONTROL_ONES};
    end else if (hits(a, standby_pkg::OFF_WATCHDOG_CONTROL)) begin
      r[7:0] = {s.watchdog_overflow_flag, s.watchdog_timer_mode_select,
                s.watchdog_run_enable, 2'h0, s.watchdog_clock_select};
    end else if (hits(a, standby_pkg::OFF_WATCHDOG_RESET_CONTROL)) begin
      r[7:0] = s.watchdog_reset_control;
    end else if (hits(a, standby_pkg::OFF_WATCHDOG_COUNT)) begin
      r[7:0] = count;
    end else if (hits(a, standby_pkg::OFF_INTERRUPT_CONTROL)) begin
      r[standby_pkg::POS_WAKE_EDGE] = s.wake_edge_select;
    end else if (hits(a, standby_pkg::OFF_STANDBY_STATUS)) begin
      r[standby_pkg::POS_STAT_STANDBY] = s.phase == standby_pkg::PHASE_STANDBY;
      r[standby_pkg::POS_STAT_WAKING] = s.phase == standby_pkg::PHASE_WAKE;
      r[standby_pkg::POS_STAT_DMA_UNDEF] = s.dma_addr_undefined;
    end else begin
      r[32] = 1'b1;
    end
    return r;
  endfunction : read_word

  // ****************************************
  // Watchdog counter
  // ****************************************
  assign wdt_count_enable = (st.phase == standby_pkg::PHASE_WAKE) ||
                            (st.phase == standby_pkg::PHASE_RUN && st.watchdog_run_enable);
  assign wdt_clear = !st.res_sync;
  assign reg_write = st.aw_got && st.w_got && !st.bvalid;
  assign wdt_load = reg_write && st.w_lane0 && hits(st.aw_addr, standby_pkg::OFF_WATCHDOG_COUNT);
  // Pin levels held across entry and resume make the selected edge real
  assign nmi_edge = st.wake_edge_select ? (st.nmi_sync && !st.nmi_prev) :
                                          (!st.nmi_sync && st.nmi_prev);

  watchdog_counter u_wdt (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .count_enable(wdt_count_enable),
    .clear(wdt_clear),
    .load(wdt_load),
    .load_value(st.w_data),
    .watchdog_clock_select(st.watchdog_clock_select),
    .watchdog_count(wdt_count),
    .overflow(wdt_overflow)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [32:0] rd;
    rd = '0;
    n = st;
    n.res_meta = reset_pin_n;
    n.res_sync = st.res_meta;
    n.nmi_meta = nmi_pin;
    n.nmi_sync = st.nmi_meta;
    n.nmi_prev = st.nmi_sync;
    n.dma_ctrl_reinit = 1'b0;
    n.periph_reinit = 1'b0;
    n.nmi_exception = 1'b0;
    n.power_on_reset = 1'b0;

    // Bus: address and data taken in either order
    if (awvalid && st.awready) begin
      n.aw_got = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && st.wready) begin
      n.w_got = 1'b1;
      n.w_data = wdata[7:0];
      n.w_lane0 = wstrb[0];
    end
    if (st.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (reg_write) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      rd = read_word(st.aw_addr, st, wdt_count);
      n.bresp = rd[32] ? standby_pkg::RESP_SLVERR : standby_pkg::RESP_OKAY;
      if (st.w_lane0) begin
        if (hits(st.aw_addr, standby_pkg::OFF_STANDBY_CONTROL) && !st.watchdog_run_enable) begin
          n.standby_select_bit = st.w_data[standby_pkg::POS_STANDBY_SELECT];
          n.port_float_select = st.w_data[standby_pkg::POS_PORT_FLOAT];
        end
        if (hits(st.aw_addr, standby_pkg::OFF_WATCHDOG_CONTROL)) begin
          if (!st.w_data[standby_pkg::POS_WDT_OVERFLOW]) begin
            n.watchdog_overflow_flag = 1'b0;
          end
          n.watchdog_timer_mode_select = st.w_data[standby_pkg::POS_WDT_MODE];
          n.watchdog_run_enable = st.w_data[standby_pkg::POS_WDT_RUN];
          n.watchdog_clock_select = st.w_data[2:0];
        end
        if (hits(st.aw_addr, standby_pkg::OFF_WATCHDOG_RESET_CONTROL)) begin
          n.watchdog_reset_control = st.w_data;
        end
        if (hits(st.aw_addr, standby_pkg::OFF_INTERRUPT_CONTROL)) begin
          n.wake_edge_select = st.w_data[standby_pkg::POS_WAKE_EDGE];
        end
      end
    end
    if (arvalid && st.arready) begin
      rd = read_word(araddr, st, wdt_count);
      n.rvalid = 1'b1;
      n.rdata = rd[31:0];
      n.rresp = rd[32] ? standby_pkg::RESP_SLVERR : standby_pkg::RESP_OKAY;
    end else if (st.rvalid && rready) begin
      n.rvalid = 1'b0;
    end

    // Overflow while running; set wins over clear
    if (st.phase == standby_pkg::PHASE_RUN && wdt_overflow) begin
      n.watchdog_overflow_flag = 1'b1;
    end

    // Power phases
    unique case (st.phase)
      standby_pkg::PHASE_RUN: begin
        if (sleep_exec && st.standby_select_bit) begin
          n.phase = standby_pkg::PHASE_STANDBY;
          n.dma_ctrl_reinit = 1'b1;
          n.dma_addr_undefined = 1'b1;
          n.periph_reinit = 1'b1;
          // Select field and count stay as they are
          n.watchdog_overflow_flag = 1'b0;
          n.watchdog_timer_mode_select = 1'b0;
          n.watchdog_run_enable = 1'b0;
          n.watchdog_reset_control = standby_pkg::RST_WATCHDOG_RESET_CONTROL;
          // Control, edge select and float select kept as they are
        end
      end
      standby_pkg::PHASE_STANDBY: begin
        if (nmi_edge) begin
          n.phase = standby_pkg::PHASE_WAKE;
        end
      end
      standby_pkg::PHASE_WAKE: begin
        if (wdt_overflow) begin
          n.phase = standby_pkg::PHASE_RUN;
          n.nmi_exception = 1'b1;
        end
      end
      default: begin
        n.phase = standby_pkg::PHASE_RUN;
      end
    endcase

    // Reset pin acts as power-on reset
    if (!st.res_sync) begin
      n.phase = standby_pkg::PHASE_RUN;
      n.power_on_reset = 1'b1;
      n.standby_select_bit = standby_pkg::RST_STANDBY_CONTROL[standby_pkg::POS_STANDBY_SELECT];
      n.port_float_select = standby_pkg::RST_STANDBY_CONTROL[standby_pkg::POS_PORT_FLOAT];
      n.wake_edge_select = 1'b0;
      n.watchdog_overflow_flag = 1'b0;
      n.watchdog_timer_mode_select = 1'b0;
      n.watchdog_run_enable = 1'b0;
      n.watchdog_clock_select = standby_pkg::RST_WATCHDOG_CLOCK_SELECT;
      n.watchdog_reset_control = standby_pkg::RST_WATCHDOG_RESET_CONTROL;
      n.dma_addr_undefined = 1'b0;
      n.dma_ctrl_reinit = 1'b0;
      n.periph_reinit = 1'b0;
      n.nmi_exception = 1'b0;
    end

    // Outputs follow the phase being entered
    n.sys_clock_enable = n.phase == standby_pkg::PHASE_RUN;
    n.cpu_halt = n.phase != standby_pkg::PHASE_RUN;
    n.reg_retain = n.phase != standby_pkg::PHASE_RUN;
    n.osc_enable = n.phase != standby_pkg::PHASE_STANDBY;
    n.wdt_clock_enable = n.phase != standby_pkg::PHASE_STANDBY;
    n.port_float = n.reg_retain && n.port_float_select;
    n.port_hold = n.reg_retain && !n.port_float_select;
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    n.arready = !n.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.phase <= standby_pkg::PHASE_RUN;
    end else if (clk_en) begin
      st <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign cpu_halt = st.cpu_halt;
  assign reg_retain = st.reg_retain;
  assign nmi_exception = st.nmi_exception;
  assign osc_enable = st.osc_enable;
  assign sys_clock_enable = st.sys_clock_enable;
  assign wdt_clock_enable = st.wdt_clock_enable;
  assign port_hold = st.port_hold;
  assign port_float = st.port_float;
  assign dma_ctrl_reinit = st.dma_ctrl_reinit;
  assign dma_addr_undefined = st.dma_addr_undefined;
  assign periph_reinit = st.periph_reinit;
  assign power_on_reset = st.power_on_reset;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !clk_en);

  a_sby_refused: assert property (
    reg_write && st.watchdog_run_enable && st.res_sync &&
    hits(st.aw_addr, standby_pkg::OFF_STANDBY_CONTROL)
    |=> $stable(st.standby_select_bit))
    else $error("standby bit changed while watchdog runs");

  a_standby_entry: assert property (
    st.phase == standby_pkg::PHASE_RUN && sleep_exec && st.standby_select_bit && st.res_sync
    |=> st.phase == standby_pkg::PHASE_STANDBY && dma_ctrl_reinit && periph_reinit)
    else $error("sleep with standby bit did not enter standby");

  a_clock_halt: assert property (
    st.phase == standby_pkg::PHASE_STANDBY |-> !sys_clock_enable && cpu_halt && !osc_enable)
    else $error("clock or CPU running in standby");

  a_port_float: assert property (
    st.phase != standby_pkg::PHASE_RUN |-> port_float == st.port_float_select && port_hold != port_float)
    else $error("port state does not follow float select");

  a_wdt_entry: assert property (
    st.phase == standby_pkg::PHASE_RUN && $past(st.phase) == standby_pkg::PHASE_RUN ##1
    st.phase == standby_pkg::PHASE_STANDBY |-> !st.watchdog_run_enable &&
    !st.watchdog_overflow_flag && st.watchdog_reset_control == 8'h00 &&
    st.watchdog_clock_select == $past(st.watchdog_clock_select))
    else $error("watchdog fields wrong after standby entry");

  a_only_nmi: assert property (
    st.phase == standby_pkg::PHASE_STANDBY && !nmi_edge && st.res_sync
    |=> st.phase == standby_pkg::PHASE_STANDBY)
    else $error("standby left without NMI or reset");

  a_wake_clocks: assert property (
    st.phase == standby_pkg::PHASE_WAKE |-> osc_enable && wdt_clock_enable && !sys_clock_enable)
    else $error("wrong clocks while waking");

  a_wake_exit: assert property (
    st.phase == standby_pkg::PHASE_WAKE && wdt_overflow && st.res_sync
    |=> st.phase == standby_pkg::PHASE_RUN && nmi_exception ##1 !nmi_exception)
    else $error("overflow did not resume the chip");

  a_por_exit: assert property (
    !st.res_sync |=> st.phase == standby_pkg::PHASE_RUN && power_on_reset && !cpu_halt)
    else $error("reset pin did not end standby");

endmodule : standby_mode_controller
`default_nettype wire

// ---- standby_pkg.sv ----
`default_nettype none
package standby_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_STANDBY_CONTROL = 8'h00;
  localparam logic [7:0] OFF_WATCHDOG_CONTROL = 8'h04;
  localparam logic [7:0] OFF_WATCHDOG_RESET_CONTROL = 8'h08;
  localparam logic [7:0] OFF_WATCHDOG_COUNT = 8'h0C;
  localparam logic [7:0] OFF_INTERRUPT_CONTROL = 8'h10;
  localparam logic [7:0] OFF_STANDBY_STATUS = 8'h14;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int POS_STANDBY_SELECT = 7;
  localparam int POS_PORT_FLOAT = 6;
  localparam int POS_WDT_OVERFLOW = 7;
  localparam int POS_WDT_MODE = 6;
  localparam int POS_WDT_RUN = 5;
  localparam int POS_WAKE_EDGE = 0;
  localparam int POS_STAT_STANDBY = 0;
  localparam int POS_STAT_WAKING = 1;
  localparam int POS_STAT_DMA_UNDEF = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_STANDBY_CONTROL = 8'h1F;
  localparam logic [4:0] STANDBY_CONTROL_ONES = 5'h1F;
  localparam logic [7:0] RST_WATCHDOG_RESET_CONTROL = 8'h00;
  localparam logic [2:0] RST_WATCHDOG_CLOCK_SELECT = 3'h0;

  // ****************************************
  // Bus answers
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Watchdog prescaler
  // ****************************************
  localparam int PRESCALE_WIDTH = 16;
  localparam int COUNT_WIDTH = 8;

  // ****************************************
  // Power phases
  // ****************************************
  typedef enum logic [2:0] {
    PHASE_RUN = 3'b001,
    PHASE_STANDBY = 3'b010,
    PHASE_WAKE = 3'b100
  } standby_phase_type;

endpackage : standby_pkg
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, sleep_exec, nmi_pin, reset_pin_n, cpu_halt, reg_retain, nmi_exception;
  logic osc_enable, sys_clock_enable, wdt_clock_enable, port_hold, port_float;
  logic dma_ctrl_reinit, dma_addr_undefined, periph_reinit, power_on_reset;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] model [logic [7:0]];
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  standby_mode_controller DUT (
    .aclk, .aresetn, .clk_en(1'b1), .awvalid, .awready, .awaddr, .awprot(3'h0),
    .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
    .sleep_exec, .cpu_halt, .reg_retain, .nmi_exception, .nmi_pin, .reset_pin_n,
    .osc_enable, .sys_clock_enable, .wdt_clock_enable, .port_hold, .port_float,
    .dma_ctrl_reinit, .dma_addr_undefined, .periph_reinit, .power_on_reset
  );
  far_side_model far (.aclk, .sleep_exec, .nmi_pin, .reset_pin_n);

  // ****************************************
  // Register model and checking
  // ****************************************
  function automatic void mdl_reset();
    model[8'h00] = 8'h1F;
    for (int a = 4; a < 24; a += 4) model[8'(a)] = 8'h00;
  endfunction : mdl_reset

  function automatic void mdl_write(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h00: if (!model[8'h04][5]) model[a] = {d[7:6], 6'h1F};
      8'h04: model[a] = {model[a][7] & d[7], d[6:5], 2'h0, d[2:0]};
      8'h08, 8'h0C: model[a] = d;
      8'h10: model[a] = {7'h0, d[0]};
      default: ;
    endcase
  endfunction : mdl_write

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    n_compared++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  // ****************************************
  // Bus master
  // ****************************************
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    int k;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    check(k < 100, 1'b1, "write answer");
    check(bresp, resp, "write response");
    if (resp == standby_pkg::RESP_OKAY) mdl_write(a, d[7:0]);
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, input logic [1:0] resp, output logic [31:0] d);
    int k;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    d = rdata;
    check(k < 100, 1'b1, "read answer");
    check(rresp, resp, "read response");
  endtask : bus_read

  task automatic expect_reg(input logic [7:0] a);
    logic [31:0] d;
    bus_read(a, standby_pkg::RESP_OKAY, d);
    check(d, {24'h0, model[a]}, "register");
  endtask : expect_reg

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      $display("unexpected at %0t: timeout", $time);
      end_of_test();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [31:0] d;
    int n, p;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    void'($urandom(50718));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    mdl_reset();
    for (int a = 0; a < 24; a += 4) expect_reg(8'(a));
    bus_read(8'h18, standby_pkg::RESP_SLVERR, d);
    check(d, 32'h0, "unmapped read");
    bus_write(8'h20, 32'h0, standby_pkg::RESP_SLVERR);
    bus_write(8'h04, 32'h20, standby_pkg::RESP_OKAY);
    bus_write(8'h00, 32'hC0, standby_pkg::RESP_OKAY);
    expect_reg(8'h00);
    bus_write(8'h0C, 32'hF0, standby_pkg::RESP_OKAY);
    repeat (40) @(posedge aclk);
    model[8'h04][7] = 1'b1;
    bus_write(8'h04, 32'h80, standby_pkg::RESP_OKAY);
    expect_reg(8'h04);
    bus_write(8'h04, 32'h0, standby_pkg::RESP_OKAY);
    expect_reg(8'h04);
    bus_write(8'h08, 32'($urandom & 32'hFF), standby_pkg::RESP_OKAY);
    expect_reg(8'h08);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      // Fast select 0 or 1 keeps overflow beyond oscillator settling
      p = 1 << (2 * i[1] + 1);
      bus_write(8'h10, {31'h0, i[0]}, standby_pkg::RESP_OKAY);
      bus_write(8'h04, 32'h40 | 32'(i[1]), standby_pkg::RESP_OKAY);
      bus_write(8'h08, 32'($urandom & 32'hFF), standby_pkg::RESP_OKAY);
      bus_write(8'h0C, 32'hF0, standby_pkg::RESP_OKAY);
      bus_write(8'h00, {24'h0, 1'b1, i[1], 6'h0}, standby_pkg::RESP_OKAY);
      expect_reg(8'h00);
      far.arm(i[0]);
      repeat (4) @(posedge aclk);
      far.sleep_now();
      @(posedge aclk);
      check({cpu_halt, sys_clock_enable, osc_enable, wdt_clock_enable, reg_retain},
            5'b10001, "entry clocks");
      check({port_hold, port_float, dma_ctrl_reinit, periph_reinit},
            {~i[1], i[1], 2'b11}, "entry effects");
      model[8'h04] &= 8'h07;
      model[8'h08] = 8'h00;
      model[8'h14] = 8'h04;
      far.sleep_now();
      repeat (6) @(posedge aclk);
      check({cpu_halt, osc_enable, dma_addr_undefined}, 3'b101, "still asleep");
      expect_reg(8'h0C);
      far.wake(i[0]);
      n = 0;
      while (!osc_enable && n < 20) begin
        @(posedge aclk);
        n++;
      end
      check({n < 8, sys_clock_enable, wdt_clock_enable}, 3'b101, "oscillator");
      n = 0;
      while (!nmi_exception && n < 400) begin
        @(posedge aclk);
        n++;
      end
      // Sixteen ticks from 0xF0; first tick may land anywhere in one period
      check(n >= 15 * p + 2 && n <= 16 * p + 1, 1'b1, "wake interval");
      check({sys_clock_enable, cpu_halt}, 2'b10, "running");
      model[8'h0C] = 8'h00;
      for (int a = 0; a < 24; a += 4) expect_reg(8'(a));
    end
    $display("test standby and wake done");
    far.sleep_now();
    @(posedge aclk);
    check(cpu_halt, 1'b1, "asleep again");
    far.pin_reset(4);
    check(power_on_reset, 1'b1, "reset seen");
    repeat (6) @(posedge aclk);
    check({cpu_halt, sys_clock_enable, dma_addr_undefined}, 3'b010, "reset exit");
    mdl_reset();
    for (int a = 0; a < 24; a += 4) expect_reg(8'(a));
    $display("test reset pin done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire

// ---- watchdog_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module watchdog_counter #(
  parameter int PRESCALE_WIDTH = standby_pkg::PRESCALE_WIDTH,
  parameter int COUNT_WIDTH = standby_pkg::COUNT_WIDTH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Control
  input wire logic count_enable,
  input wire logic clear,
  input wire logic load,
  input wire logic [COUNT_WIDTH-1:0] load_value,
  input wire logic [2:0] watchdog_clock_select,
  // Result
  output logic [COUNT_WIDTH-1:0] watchdog_count,
  output logic overflow
);

  typedef struct packed {
    logic [PRESCALE_WIDTH-1:0] prescale;
    logic [COUNT_WIDTH-1:0] count;
    logic overflow;
  } wdt_state_type;

  wdt_state_type st;
  wdt_state_type n;

  // Tick divides by 2, 8, 32 ... as the select grows
  function automatic logic [PRESCALE_WIDTH-1:0] tick_mask(input logic [2:0] sel);
    logic [PRESCALE_WIDTH:0] one;
    one = (PRESCALE_WIDTH+1)'(1) << (5'(sel) * 5'd2 + 5'd1);
    return PRESCALE_WIDTH'(one - (PRESCALE_WIDTH+1)'(1));
  endfunction : tick_mask

  always_comb begin
    logic [PRESCALE_WIDTH-1:0] mask;
    mask = tick_mask(watchdog_clock_select);
    n = st;
    n.overflow = 1'b0;
    if (clear) begin
      n.prescale = '0;
      n.count = '0;
    end else if (load) begin
      n.count = load_value;
    end else if (count_enable) begin
      n.prescale = st.prescale + PRESCALE_WIDTH'(1);
      if ((st.prescale & mask) == mask) begin
        n.count = st.count + COUNT_WIDTH'(1);
        n.overflow = &st.count;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else if (clk_en) begin
      st <= n;
    end
  end

  assign watchdog_count = st.count;
  assign overflow = st.overflow;

endmodule : watchdog_counter
`default_nettype wire
